// [hw/lsd_defines.svh]
// Purpose: Offsets, fields, reset values and timing counts of the source driver front end
// Assumes: 200 MHz system clock
// Notes: Definitions only
`ifndef LSD_DEFINES_SVH
`define LSD_DEFINES_SVH
`define LSD_CLK_MHZ 200
`define LSD_SHORT_NS 40
`define LSD_SHORT_CYC ((`LSD_SHORT_NS * `LSD_CLK_MHZ + 999) / 1000)
`define LSD_NUM_OUT 804
`define LSD_DIFF_W 9
`define LSD_PIX_W 18
`define LSD_ADDR_W 8
`define LSD_REG_CTRL 8'h00
`define LSD_REG_STATUS 8'h04
`define LSD_REG_PIX_IDX 8'h08
`define LSD_REG_PIX_DATA 8'h0C
`define LSD_REG_LINES 8'h10
`define LSD_CTRL_RESET 8'h00
`define LSD_CTRL_IF_PAR 0
`define LSD_CTRL_DIFF_INV 1
`define LSD_CTRL_DIR_RIGHT 2
`define LSD_CTRL_SHARE_A 3
`define LSD_CTRL_SHARE_B 4
`define LSD_CTRL_SEL_LO 5
`define LSD_SEL_804 3'h0
`define LSD_SEL_768 3'h1
`define LSD_SEL_720 3'h2
`define LSD_SEL_684 3'h3
`define LSD_SKIP768_LO 128
`define LSD_SKIP768_HI 139
`define LSD_SKIP720_LO 120
`define LSD_SKIP720_HI 147
`define LSD_SKIP684_LO 114
`define LSD_SKIP684_HI 153
`define LSD_RESP_OKAY 2'h0
`define LSD_RESP_SLVERR 2'h2
`endif

// [hw/lsd_pkg.sv]
// Purpose: Types of the source driver front end
// Assumes: Nothing
// Notes: Constants live in lsd_defines.svh
package lsd_pkg;
    typedef logic [17:0] lsd_pix_t;
    typedef enum logic [1:0] {
        LSD_IDLE = 2'b01,
        LSD_LOAD = 2'b10
    } lsd_load_t;
endpackage

// [hw/lsd_reg_if.sv]
// Purpose: Register access path between bus slave and core
// Assumes: One clock domain
// Notes: Hit flags come back combinationally
`timescale 1ns/1ps
`include "lsd_defines.svh"
interface lsd_reg_if;
    logic wr_en;
    logic [`LSD_ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_hit;
    logic [`LSD_ADDR_W-1:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_hit;
    modport slave(output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                  input wr_hit, rd_data, rd_hit);
    modport core(input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                 output wr_hit, rd_data, rd_hit);
endinterface

// [hw/lsd_edge_det.sv]
// Purpose: Rising and falling edge detection of a synchronous level
// Assumes: Level is synchronous to clk
// Notes: Pulses last one clock
`timescale 1ns/1ps
module lsd_edge_det (
    input wire logic clk,
    input wire logic rst,
    input wire logic level,
    output logic rise,
    output logic fall
);
    logic prev_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= level;
        end
    end

    assign rise = level & ~prev_reg;
    assign fall = ~level & prev_reg;
endmodule

// [hw/lsd_axil_slave.sv]
// Purpose: AXI4-Lite slave feeding the register path
// Assumes: One write and one read in flight
// Notes: Address and data of a write taken in either order
`timescale 1ns/1ps
`include "lsd_defines.svh"
module lsd_axil_slave (
    input wire logic clk,
    input wire logic rst,
    input wire logic [`LSD_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`LSD_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    lsd_reg_if.slave rif
);
    logic aw_full_reg;
    logic w_full_reg;
    logic [`LSD_ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic do_write;

    assign s_axi_awready = ~aw_full_reg;
    assign s_axi_wready = ~w_full_reg;
    assign s_axi_arready = ~s_axi_rvalid;
    assign do_write = aw_full_reg & w_full_reg & ~s_axi_bvalid;
    assign rif.wr_en = do_write;
    assign rif.wr_addr = {awaddr_reg[`LSD_ADDR_W-1:2], 2'b00};
    assign rif.wr_data = wdata_reg;
    assign rif.wr_strb = wstrb_reg;
    assign rif.rd_addr = {s_axi_araddr[`LSD_ADDR_W-1:2], 2'b00};

    // Write capture and response
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `LSD_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_full_reg) begin
                aw_full_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_full_reg) begin
                w_full_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= rif.wr_hit ? `LSD_RESP_OKAY : `LSD_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read answer one clock after address
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `LSD_RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rif.rd_data;
            s_axi_rresp <= rif.rd_hit ? `LSD_RESP_OKAY : `LSD_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// [hw/lsd_source_front.sv]
// Purpose: Digital front end of a TFT column driver: pixel capture, latch, share control
// Assumes: All pins synchronous to clk; shift clock far slower than clk
// Notes: Mode pins are control register bits; latched levels read over the bus
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "lsd_defines.svh"
module lsd_source_front #(
    parameter int NUM_OUT = `LSD_NUM_OUT,
    parameter int SHORT_CYC = `LSD_SHORT_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [`LSD_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`LSD_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic diff_shift_clock_pos,
    input wire logic diff_shift_clock_neg,
    input wire logic [`LSD_DIFF_W-1:0] diff_data_pairs_pos,
    input wire logic [`LSD_DIFF_W-1:0] diff_data_pairs_neg,
    input wire lsd_pkg::lsd_pix_t parallel_data_bus,
    input wire logic parallel_invert,
    input wire logic right_start_pulse_in,
    output logic right_start_pulse_out,
    output logic right_start_pulse_oe,
    input wire logic left_start_pulse_in,
    output logic left_start_pulse_out,
    output logic left_start_pulse_oe,
    input wire logic line_strobe,
    input wire logic polarity_select,
    input wire logic frame_pulse,
    output logic charge_share,
    output logic drive_on,
    output logic odd_upper_range
);
    import lsd_pkg::*;

    localparam int NPIX = NUM_OUT / 3;
    localparam int PW = $clog2(NPIX);
    localparam int CW = $clog2(SHORT_CYC + 1);
    lsd_reg_if rif();
    logic [7:0] ctrl_reg;
    logic [PW-1:0] pix_idx_reg;
    lsd_load_t load_reg;
    logic [PW-1:0] pos_reg;
    logic half_reg;
    logic [`LSD_DIFF_W-1:0] lo_half_reg;
    logic start_out_reg;
    lsd_pix_t data_mem [NPIX];
    lsd_pix_t latch_mem [NPIX];
    logic pol_latched_reg;
    logic pol_prev_reg;
    logic share_reg;
    logic drive_reg;
    logic [CW-1:0] short_cnt_reg;
    logic [15:0] line_cnt_reg;
    logic [15:0] last_lines_reg;

    logic if_par;
    logic dir_right;
    logic [2:0] chan_sel;
    logic bad_sel;
    logic shift_lvl;
    logic sh_rise;
    logic sh_fall;
    logic stb_rise;
    logic stb_fall;
    logic frm_rise;
    logic [`LSD_DIFF_W-1:0] diff_bits;
    lsd_pix_t diff_pix;
    lsd_pix_t cap_pix;
    logic invert;
    logic start_in;
    logic cap_now;
    logic at_last;
    logic [PW-1:0] first_pos;
    logic [PW-1:0] last_pos;
    logic pol_changed;
    logic share_next;
    lsd_pix_t pix_rd;

    lsd_axil_slave u_axi (.*, .rif(rif.slave));

    // Mode bits; reset matches the pulled-down pins
    assign if_par = ctrl_reg[`LSD_CTRL_IF_PAR];
    assign dir_right = ctrl_reg[`LSD_CTRL_DIR_RIGHT];
    assign chan_sel = ctrl_reg[`LSD_CTRL_SEL_LO +: 3];
    assign bad_sel = chan_sel > `LSD_SEL_684;

    // Pair decode, differential clock or plain clock
    assign diff_bits = diff_data_pairs_pos & ~diff_data_pairs_neg;
    assign shift_lvl = if_par ? diff_shift_clock_pos
                              : (diff_shift_clock_pos & ~diff_shift_clock_neg);

    lsd_edge_det u_shift_edge (.clk(clk), .rst(rst), .level(shift_lvl),
        .rise(sh_rise), .fall(sh_fall));
    lsd_edge_det u_stb_edge (.clk(clk), .rst(rst), .level(line_strobe),
        .rise(stb_rise), .fall(stb_fall));
    lsd_edge_det u_frame_edge (.clk(clk), .rst(rst), .level(frame_pulse),
        .rise(frm_rise), .fall());

    // Dot k: low 3 bits on rising half, high 3 bits on falling half
    for (genvar k = 0; k < 3; k++) begin : g_dot
        assign diff_pix[6*k +: 6] = {diff_bits[3*k +: 3], lo_half_reg[3*k +: 3]};
    end

    assign invert = if_par ? parallel_invert : ctrl_reg[`LSD_CTRL_DIFF_INV];
    assign cap_pix = (if_par ? parallel_data_bus : diff_pix) ^ {`LSD_PIX_W{invert}};
    assign cap_now = (load_reg == LSD_LOAD)
                     && (if_par ? sh_rise : (sh_fall && half_reg));

    // Start and end of the fill follow the direction
    assign start_in = dir_right ? right_start_pulse_in : left_start_pulse_in;
    assign first_pos = dir_right ? '0 : PW'(NPIX - 1);
    assign last_pos = dir_right ? PW'(NPIX - 1) : '0;
    assign at_last = pos_reg == last_pos;

    // Next pixel position, jumping over the switched-off middle block
    function automatic logic [PW-1:0] next_pos(input logic [PW-1:0] p, input logic right,
                                               input logic [2:0] sel);
        logic [PW-1:0] lo;
        logic [PW-1:0] hi;
        logic [PW-1:0] n;
        logic skip;
        lo = '0;
        hi = '0;
        skip = 1'b1;
        n = right ? p + 1'b1 : p - 1'b1;
        case (sel)
            `LSD_SEL_768: begin
                lo = PW'(`LSD_SKIP768_LO);
                hi = PW'(`LSD_SKIP768_HI);
            end
            `LSD_SEL_720: begin
                lo = PW'(`LSD_SKIP720_LO);
                hi = PW'(`LSD_SKIP720_HI);
            end
            `LSD_SEL_684: begin
                lo = PW'(`LSD_SKIP684_LO);
                hi = PW'(`LSD_SKIP684_HI);
            end
            default: skip = 1'b0;
        endcase
        if (skip && n >= lo && n <= hi) begin
            n = right ? hi + 1'b1 : lo - 1'b1;
        end
        return n;
    endfunction

    // Load sequencer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            load_reg <= LSD_IDLE;
            pos_reg <= '0;
            half_reg <= 1'b0;
            lo_half_reg <= '0;
        end else begin
            unique case (load_reg)
                LSD_IDLE: begin
                    if (sh_rise && start_in) begin
                        load_reg <= LSD_LOAD;
                        pos_reg <= first_pos;
                        half_reg <= 1'b0;
                    end
                end
                LSD_LOAD: begin
                    if (sh_rise && !if_par) begin
                        lo_half_reg <= diff_bits;
                        half_reg <= 1'b1;
                    end
                    if (cap_now) begin
                        half_reg <= 1'b0;
                        if (at_last) begin
                            load_reg <= LSD_IDLE;
                        end else begin
                            pos_reg <= next_pos(pos_reg, dir_right, chan_sel);
                        end
                    end
                end
            endcase
        end
    end

    // Outgoing start pulse, from the last capture until the next shift clock rise
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            start_out_reg <= 1'b0;
        end else if (cap_now && at_last) begin
            start_out_reg <= 1'b1;
        end else if (sh_rise) begin
            start_out_reg <= 1'b0;
        end
    end

    assign right_start_pulse_oe = ~dir_right;
    assign left_start_pulse_oe = dir_right;
    assign right_start_pulse_out = ~dir_right & start_out_reg;
    assign left_start_pulse_out = dir_right & start_out_reg;

    // Data register
    always_ff @(posedge clk) begin
        if (cap_now) begin
            data_mem[pos_reg] <= cap_pix;
        end
    end

    // Output latch
    always_ff @(posedge clk) begin
        if (stb_rise) begin
            latch_mem <= data_mem;
        end
    end

    // Polarity and charge share
    assign pol_changed = stb_rise ? (polarity_select != pol_latched_reg)
                                  : (pol_latched_reg != pol_prev_reg);
    assign share_next = line_strobe && !ctrl_reg[`LSD_CTRL_SHARE_A]
                        && (ctrl_reg[`LSD_CTRL_SHARE_B] || pol_changed);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pol_latched_reg <= 1'b0;
            pol_prev_reg <= 1'b0;
        end else if (stb_rise) begin
            pol_latched_reg <= polarity_select;
            pol_prev_reg <= pol_latched_reg;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            share_reg <= 1'b0;
        end else begin
            share_reg <= share_next;
        end
    end

    // Drive off from strobe rise until SHORT_CYC clocks after its fall
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            drive_reg <= 1'b0;
            short_cnt_reg <= '0;
        end else if (stb_rise) begin
            drive_reg <= 1'b0;
            short_cnt_reg <= '0;
        end else if (stb_fall) begin
            short_cnt_reg <= CW'(SHORT_CYC);
        end else if (short_cnt_reg == CW'(1)) begin
            drive_reg <= 1'b1;
            short_cnt_reg <= '0;
        end else if (short_cnt_reg != '0) begin
            short_cnt_reg <= short_cnt_reg - 1'b1;
        end
    end

    assign charge_share = share_reg;
    assign drive_on = drive_reg;
    assign odd_upper_range = pol_latched_reg;

    // Strobes per frame
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            line_cnt_reg <= '0;
            last_lines_reg <= '0;
        end else if (frm_rise) begin
            last_lines_reg <= line_cnt_reg;
            line_cnt_reg <= stb_rise ? 16'h0001 : 16'h0000;
        end else if (stb_rise) begin
            line_cnt_reg <= line_cnt_reg + 1'b1;
        end
    end

    // Register writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= `LSD_CTRL_RESET;
            pix_idx_reg <= '0;
        end else if (rif.wr_en) begin
            if (rif.wr_addr == `LSD_REG_CTRL && rif.wr_strb[0]) begin
                ctrl_reg <= rif.wr_data[7:0];
            end
            if (rif.wr_addr == `LSD_REG_PIX_IDX) begin
                if (rif.wr_strb[0]) begin
                    pix_idx_reg[7:0] <= rif.wr_data[7:0];
                end
                if (rif.wr_strb[1]) begin
                    pix_idx_reg[PW-1:8] <= rif.wr_data[PW-1:8];
                end
            end
        end
    end

    assign rif.wr_hit = rif.wr_addr == `LSD_REG_CTRL || rif.wr_addr == `LSD_REG_PIX_IDX;

    assign pix_rd = (pix_idx_reg < PW'(NPIX)) ? latch_mem[pix_idx_reg] : '0;

    // Register reads
    always_comb begin
        rif.rd_data = 32'h0000_0000;
        rif.rd_hit = 1'b1;
        case (rif.rd_addr)
            `LSD_REG_CTRL: rif.rd_data[7:0] = ctrl_reg;
            `LSD_REG_STATUS: begin
                rif.rd_data[0] = load_reg == LSD_LOAD;
                rif.rd_data[1] = bad_sel;
                rif.rd_data[2] = share_reg;
                rif.rd_data[3] = drive_reg;
                rif.rd_data[4] = pol_latched_reg;
                rif.rd_data[5] = start_out_reg;
                rif.rd_data[16 +: PW] = pos_reg;
            end
            `LSD_REG_PIX_IDX: rif.rd_data[PW-1:0] = pix_idx_reg;
            `LSD_REG_PIX_DATA: rif.rd_data[`LSD_PIX_W-1:0] = pix_rd;
            `LSD_REG_LINES: rif.rd_data = {line_cnt_reg, last_lines_reg};
            default: begin
                rif.rd_hit = 1'b0;
            end
        endcase
    end
endmodule

// [tb/lsd_source_front_props.sv]
// Purpose: Port checks of the source driver front end
// Assumes: One clock, async active-high reset
// Notes: Bound to the top module
`timescale 1ns/1ps
module lsd_source_front_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic line_strobe,
    input wire logic polarity_select,
    input wire logic charge_share,
    input wire logic drive_on,
    input wire logic odd_upper_range,
    input wire logic right_start_pulse_out,
    input wire logic right_start_pulse_oe,
    input wire logic left_start_pulse_out,
    input wire logic left_start_pulse_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_drive_cut: assert property ($rose(line_strobe) |=> !drive_on)
        else $error("drive on after strobe rise");
    a_drive_back: assert property ($fell(line_strobe) |=> (!drive_on)[*6] ##[1:3] drive_on)
        else $error("drive not back after short");
    a_share_gate: assert property (charge_share |-> $past(line_strobe))
        else $error("share outside strobe high");
    a_share_end: assert property ($fell(line_strobe) |=> !charge_share)
        else $error("share after strobe fall");
    a_pol_take: assert property ($rose(line_strobe) |=> odd_upper_range == $past(polarity_select))
        else $error("polarity not latched");
    a_pol_keep: assert property (!$rose(line_strobe) |=> $stable(odd_upper_range))
        else $error("polarity moved without strobe");
    a_oe_one: assert property (right_start_pulse_oe != left_start_pulse_oe)
        else $error("start pins both or neither driven");
    a_left_gate: assert property (left_start_pulse_out |-> left_start_pulse_oe)
        else $error("left start out while not driving");
    a_right_gate: assert property (right_start_pulse_out |-> right_start_pulse_oe)
        else $error("right start out while not driving");
    c_share: cover property ($rose(charge_share));
    c_left: cover property ($rose(left_start_pulse_out));
    c_right: cover property ($rose(right_start_pulse_out));
endmodule
bind lsd_source_front lsd_source_front_props
    lsd_source_front_props_inst (.clk, .rst, .line_strobe, .polarity_select, .charge_share,
    .drive_on, .odd_upper_range, .right_start_pulse_out, .right_start_pulse_oe,
    .left_start_pulse_out, .left_start_pulse_oe);

// [tb/lsd_tcon_model.sv]
// Purpose: Timing controller model: pixels, start pulse, strobe
// Assumes: Each shift phase lasts three system clocks
// Notes: Shift clock stands low between lines
`timescale 1ns/1ps
module lsd_tcon_model (
    input wire logic clk,
    output logic diff_shift_clock_pos,
    output logic diff_shift_clock_neg,
    output logic [8:0] diff_data_pairs_pos,
    output logic [8:0] diff_data_pairs_neg,
    output logic [17:0] parallel_data_bus,
    output logic parallel_invert,
    output logic st_r,
    output logic st_l,
    output logic line_strobe,
    output logic polarity_select,
    output logic frame_pulse
);
    initial begin
        diff_shift_clock_pos = 1'b0;
        diff_shift_clock_neg = 1'b1;
        diff_data_pairs_pos = 9'h000;
        diff_data_pairs_neg = 9'h1FF;
        parallel_data_bus = 18'h00000;
        parallel_invert = 1'b0;
        st_r = 1'b0;
        st_l = 1'b0;
        line_strobe = 1'b0;
        polarity_select = 1'b0;
        frame_pulse = 1'b0;
    end
    task automatic shift(input logic lvl, input logic [8:0] b, input logic [17:0] w);
        @(posedge clk);
        diff_data_pairs_pos <= b;
        diff_data_pairs_neg <= ~b;
        parallel_data_bus <= w;
        @(posedge clk);
        diff_shift_clock_pos <= lvl;
        diff_shift_clock_neg <= !lvl;
        @(posedge clk);
    endtask
    task automatic send_line(input logic dif, input logic rgt, input int n,
                             input logic [17:0] base, input logic differential_invert);
        logic [17:0] v;
        @(posedge clk);
        st_r <= rgt;
        st_l <= !rgt;
        parallel_invert <= differential_invert;
        shift(1'b1, 9'h000, 18'h00000);
        st_r <= 1'b0;
        st_l <= 1'b0;
        shift(1'b0, 9'h000, 18'h00000);
        for (int i = 0; i < n; i++) begin
            v = base ^ 18'(i * 1237);
            if (dif) begin
                shift(1'b1, {v[14:12], v[8:6], v[2:0]}, v);
                shift(1'b0, {v[17:15], v[11:9], v[5:3]}, v);
            end else begin
                shift(1'b1, 9'h000, v);
                shift(1'b0, 9'h000, v);
            end
        end
        @(posedge clk);
        diff_data_pairs_pos <= ~diff_data_pairs_pos;
        diff_data_pairs_neg <= ~diff_data_pairs_neg;
        parallel_data_bus <= ~parallel_data_bus;
    endtask
    task automatic stb_rise(input logic p);
        @(posedge clk);
        polarity_select <= p;
        @(posedge clk);
        line_strobe <= 1'b1;
    endtask
    task automatic stb_fall();
        @(posedge clk);
        line_strobe <= 1'b0;
    endtask
    task automatic frame();
        @(posedge clk);
        frame_pulse <= 1'b1;
        @(posedge clk);
        frame_pulse <= 1'b0;
    endtask
endmodule

// [tb/tb.sv]
// Purpose: Self-checking bench of the source driver front end
// Assumes: 200 MHz clock, reset held 10 cycles
// Notes: Registers reached over AXI4-Lite
`timescale 1ns/1ps
`include "lsd_defines.svh"
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic diff_shift_clock_pos, diff_shift_clock_neg, parallel_invert, st_r, st_l;
    logic [8:0] diff_data_pairs_pos, diff_data_pairs_neg;
    logic [17:0] parallel_data_bus;
    logic right_start_pulse_in, right_start_pulse_out, right_start_pulse_oe;
    logic left_start_pulse_in, left_start_pulse_out, left_start_pulse_oe;
    logic line_strobe, polarity_select, frame_pulse, charge_share, drive_on, odd_upper_range;
    logic pol_prev = 1'b0;
    int err_count = 0, num_checks = 0, cyc = 0;
    assign right_start_pulse_in = right_start_pulse_oe ? right_start_pulse_out : st_r;
    assign left_start_pulse_in = left_start_pulse_oe ? left_start_pulse_out : st_l;
    lsd_source_front #(.SHORT_CYC(8)) lsd_source_front_inst (.*);
    lsd_tcon_model lsd_tcon_model_inst (.*);
    always #2.5 clk = ~clk;
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count = err_count + 1;
            close_out();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clk);
            if (s_axi_awready && !aw_done) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready && !w_done) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge clk);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(posedge clk);
        while (s_axi_arready !== 1'b1) @(posedge clk);
        s_axi_arvalid <= 1'b0;
        @(posedge clk);
        while (s_axi_rvalid !== 1'b1) @(posedge clk);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    function automatic logic [17:0] pix(input logic [17:0] b, input int i);
        return b ^ 18'(i * 1237);
    endfunction
    task automatic px(input int idx, input logic [17:0] exp);
        wr(`LSD_REG_PIX_IDX, 32'(idx));
        rdr(`LSD_REG_PIX_DATA);
        chk(rd, {14'h0, exp});
    endtask
    task automatic stb(input logic p);
        lsd_tcon_model_inst.stb_rise(p);
        repeat (3) @(posedge clk);
        lsd_tcon_model_inst.stb_fall();
        repeat (12) @(posedge clk);
        pol_prev = p;
    endtask
    task automatic t_regs();
        chk({drive_on, charge_share, odd_upper_range, right_start_pulse_oe}, 4'h1);
        rdr(`LSD_REG_CTRL);
        chk(rd, 32'h0);
        rdr(8'h14);
        chk(rs, `LSD_RESP_SLVERR);
        $display("test regs done");
    endtask
    task automatic t_par();
        wr(`LSD_REG_CTRL, 32'h07);
        lsd_tcon_model_inst.frame();
        lsd_tcon_model_inst.send_line(1'b0, 1'b1, 268, 18'h2A5C3, 1'b1);
        chk({left_start_pulse_out, right_start_pulse_oe}, 2'h2);
        stb(1'b1);
        px(0, ~pix(18'h2A5C3, 0));
        px(267, ~pix(18'h2A5C3, 267));
        $display("test parallel done");
    endtask
    task automatic t_diff();
        wr(`LSD_REG_CTRL, 32'h22);
        lsd_tcon_model_inst.send_line(1'b1, 1'b0, 256, 18'h1B7E4, 1'b1);
        chk({right_start_pulse_out, left_start_pulse_oe}, 2'h2);
        stb(1'b1);
        px(267, ~pix(18'h1B7E4, 0));
        px(127, ~pix(18'h1B7E4, 128));
        $display("test differential done");
    endtask
    task automatic t_share();
        logic [11:0] tab;
        logic a, b, p;
        tab = 12'b101_010_000_001;
        for (int i = 0; i < 4; i++) begin
            a = tab[3 * i + 2];
            b = tab[3 * i + 1];
            p = pol_prev ^ tab[3 * i];
            wr(`LSD_REG_CTRL, {27'h0, b, a, 3'b101});
            lsd_tcon_model_inst.stb_rise(p);
            repeat (3) @(posedge clk);
            chk(charge_share, !a && (b || p != pol_prev));
            chk(odd_upper_range, p);
            chk(drive_on, 1'b0);
            lsd_tcon_model_inst.stb_fall();
            repeat (12) @(posedge clk);
            chk(drive_on, 1'b1);
            pol_prev = p;
        end
        lsd_tcon_model_inst.frame();
        rdr(`LSD_REG_LINES);
        chk(rd, 32'h0000_0006);
        $display("test share done");
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_par();
        t_diff();
        t_share();
        close_out();
    end
endmodule
